// ==== testbench/slw_ctrl_props.sv ====
// Checker for routing and stop behaviour of slw_ctrl
`timescale 1ns/1ns
module slw_props import slw_pkg::*; (
  // Watched ports
  input wire logic sys_clk,
  input wire logic srst,
  input wire slw_stop_t stop_mode,
  input wire logic cfg_we,
  input wire slw_route_t cfg_wdata,
  input wire logic buf_load,
  input wire logic [7:0] serial_data_buffer,
  input wire logic tx_out,
  input wire logic transmit_pin_oe,
  input wire logic receive_pin_released,
  input wire logic rx_in,
  input wire slw_char_t shifter_char,
  input wire slw_route_t route_cfg,
  input wire logic clk_halted
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Decoded run state and routing
  wire run = stop_mode == SLW_RUN;
  wire lp = route_cfg[2] & !route_cfg[1];
  wire sw = route_cfg[2] & route_cfg[1];
  property p_halt; !run |=> clk_halted; endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_cfg; cfg_we && run |=> route_cfg == $past(cfg_wdata); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  property p_load;
    buf_load && run |=> shifter_char[7:0] == $past(serial_data_buffer);
  endproperty
  a_load: assert property (p_load) else $error("load");
  property p_keep;
    stop_mode == SLW_LIGHT_STOP |=>
      $stable(route_cfg) && $stable(shifter_char);
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_clr;
    stop_mode > SLW_LIGHT_STOP |=> route_cfg == 0 && shifter_char == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_loop;
    $past(lp && run) |-> rx_in == $past(tx_out) && receive_pin_released;
  endproperty
  a_loop: assert property (p_loop) else $error("loop");
  property p_sw1;
    $past(sw && route_cfg[0] && run) |->
      transmit_pin_oe && rx_in == $past(tx_out);
  endproperty
  a_sw1: assert property (p_sw1) else $error("drive");
  property p_sw0;
    $past(sw && !route_cfg[0] && run) |->
      !transmit_pin_oe && receive_pin_released;
  endproperty
  a_sw0: assert property (p_sw0) else $error("listen");
endmodule
bind slw_ctrl slw_props u_props (.sys_clk, .srst, .stop_mode, .cfg_we,
  .cfg_wdata, .buf_load, .serial_data_buffer, .tx_out, .transmit_pin_oe,
  .receive_pin_released, .rx_in, .shifter_char, .route_cfg, .clk_halted);

// ==== testbench/slw_remote.sv ====
// Remote serial party on the shared line
`timescale 1ns/1ns
module slw_remote (
  // Clock and line direction
  input wire logic sys_clk,
  input wire logic line_oe,
  // Remote drive
  output logic drv,
  output logic drv_oe
);
  // New random bit each cycle, driven only while the module listens
  assign drv_oe = !line_oe;
  always @(posedge sys_clk) drv <= 1'($urandom);
endmodule

// ==== testbench/tb_slw_ctrl.sv ====
// Bench comparing slw_ctrl against a behavioural model
`timescale 1ns/1ns
module tb_slw_ctrl;
  import slw_pkg::*;
  logic sys_clk = 0, srst = 1, cfg_we = 0, ninth_we = 0, ninth_wdata = 0;
  logic buf_load = 0, tx_out = 1, rp = 1, tpo, oe, rel, rx, hlt, ni, drv, dv;
  logic nm, hm, rxm, oem, relm, tpm, s1, s2, r1, r2;
  logic [7:0] sdb = 0;
  slw_stop_t stop_mode = SLW_RUN;
  slw_route_t cfg_wdata = 0, rm, route_cfg;
  slw_char_t sm, shifter_char;
  int fails = 0, total_checks = 0, run_n = 0;
  wire tpin = oe ? tpo : dv ? drv : SLW_LINE_IDLE;
  slw_remote rem (.sys_clk, .line_oe(oe), .drv, .drv_oe(dv));
  slw_ctrl dut (.sys_clk, .srst, .stop_mode, .cfg_we, .cfg_wdata, .ninth_we,
    .ninth_wdata, .buf_load, .serial_data_buffer(sdb), .tx_out,
    .transmit_pin_in(tpin), .receive_pin_in(rp), .transmit_pin_out(tpo),
    .transmit_pin_oe(oe), .receive_pin_released(rel), .rx_in(rx),
    .shifter_char, .route_cfg, .clk_halted(hlt), .needs_init(ni));
  always #10 sys_clk = ~sys_clk;
  // Reference model of registers and pin routing
  always @(posedge sys_clk) begin
    {s2, s1, r2, r1} <= {s1, tpin, r1, rp};
    {tpm, oem, relm} <= {tx_out, !(rm[2] & rm[1] & !rm[0]), rm[2]};
    rxm <= !rm[2] ? r2 : rm[1] & !rm[0] ? s2 : tx_out;
    hm <= !srst && stop_mode != SLW_RUN;
    run_n <= srst || stop_mode != SLW_RUN ? 0 : run_n + 1;
    if (srst || stop_mode > SLW_LIGHT_STOP) {rm, sm, nm} <= '0;
    else if (stop_mode == SLW_RUN) begin
      if (cfg_we) rm <= cfg_wdata;
      if (ninth_we) nm <= ninth_wdata;
      if (buf_load) sm <= {nm, sdb};
    end
  end
  // Compare design with model between edges
  always @(negedge sys_clk) if (!srst) begin
    chk({route_cfg, shifter_char, hlt}, {rm, sm, hm});
    if (run_n > 3) chk({rx, oe, rel, tpo}, {rxm, oem, relm, tpm});
  end
  task automatic chk(input logic [12:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Random inputs launched on the rising edge
  task automatic cyc(input int n, st, w);
    logic [15:0] r;
    repeat (n) @(posedge sys_clk) begin
      r = 16'($urandom);
      // No character is shifting while the module is stopped
      if (st != 0) r[1] = SLW_LINE_IDLE;
      stop_mode <= slw_stop_t'(st);
      cfg_we <= $urandom % w == 1;
      {ninth_we, buf_load, cfg_wdata, ninth_wdata, sdb, tx_out, rp} <= r;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0657_0034));
    repeat (16) @(posedge sys_clk);
    srst <= 0;
    cyc(400, 0, 10);
    $display("run test done");
    for (int s = 1; s < 4; s++) begin
      cyc(5, s, 2);
      cyc(8, 0, 1);
      @(negedge sys_clk);
      chk(ni, s > 1);
    end
    $display("stop test done");
    summarize();
  end
  // Watchdog
  initial begin
    #50000;
    fails++;
    summarize();
  end
endmodule

// ==== verilog/slw_ctrl.sv ====
// Ninth-bit transfer, stop-mode handling and loop/single-wire pin routing
`timescale 1ns/1ns
module slw_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Power state
  input wire slw_pkg::slw_stop_t stop_mode,
  // Configuration writes
  input wire logic cfg_we,
  input wire slw_pkg::slw_route_t cfg_wdata,
  input wire logic ninth_we,
  input wire logic ninth_wdata,
  // Transmit path
  input wire logic buf_load,
  input wire logic [7:0] serial_data_buffer,
  input wire logic tx_out,
  // Pins
  input wire logic transmit_pin_in,
  input wire logic receive_pin_in,
  output logic transmit_pin_out,
  output logic transmit_pin_oe,
  output logic receive_pin_released,
  // Receiver and status
  output logic rx_in,
  output slw_pkg::slw_char_t shifter_char,
  output slw_pkg::slw_route_t route_cfg,
  output logic clk_halted,
  output logic needs_init
);
  import slw_pkg::*;

  // Only run mode lets the ninth bit, routing and shifter registers advance
  function automatic logic stop_runs(input slw_stop_t mode);
    return mode == SLW_RUN;
  endfunction

  // Partial and deepest stops clear the ninth bit, routing and shifter registers
  function automatic logic stop_wipes(input slw_stop_t mode);
    return (mode == SLW_PARTIAL_STOP) || (mode == SLW_DEEPEST_STOP);
  endfunction

  // A write strobe counts only while the module clocks run
  function automatic logic take(input logic run, input logic strobe);
    return run && strobe;
  endfunction

  // Loop mode: loop-back on with the internal source picked
  function automatic logic is_loop(input slw_route_t cfg);
    return cfg.loopback_enable && !cfg.receiver_source_select;
  endfunction

  // Single-wire mode: loop-back on with the shared pin picked
  function automatic logic is_single(input slw_route_t cfg);
    return cfg.loopback_enable && cfg.receiver_source_select;
  endfunction

  // Control state
  logic ninth_reg, ninth_next;
  slw_route_t route_reg, route_next;
  // Pin synchronisers, two stages each
  logic [1:0] txp_sync_reg;
  logic [1:0] rxp_sync_reg;
  // Registered outputs and status
  logic tx_out_reg, tx_oe_reg, rxr_reg, rx_in_reg;
  logic halt_reg, init_reg, init_next;
  // Transmit shifter contents
  slw_char_t held;

  // Power-state decode; a stopped module freezes or wipes its state
  wire logic clk_run = stop_runs(stop_mode);
  wire logic wipe = stop_wipes(stop_mode);
  wire logic clr = srst || wipe;

  // Accepted strobes; writes during any stop are dropped silently
  wire logic ninth_take = take(clk_run, ninth_we);
  wire logic cfg_take = take(clk_run, cfg_we);

  // Mode decode from the stored routing word
  wire logic loop_mode = is_loop(route_reg);
  wire logic single_wire = is_single(route_reg);
  wire logic sw_talk = single_wire && route_reg.shared_pin_direction;
  wire logic sw_listen = single_wire && !route_reg.shared_pin_direction;

  // Transmitter owns the pin unless single-wire is listening
  wire logic drive_pin = !sw_listen;
  // Receive pin goes back to port control in both loop-back modes
  wire logic release_rx = loop_mode || single_wire;

  // Receiver source: own transmitter, shared pin, or receive pin
  wire logic rx_from_tx = loop_mode || sw_talk;
  wire logic rx_from_shared = sw_listen;
  wire logic rx_sel = rx_from_tx ? tx_out :
                      rx_from_shared ? txp_sync_reg[1] :
                      rxp_sync_reg[1];

  // Register next values; light stop simply holds them
  assign ninth_next = ninth_take ? ninth_wdata : ninth_reg;
  assign route_next = cfg_take ? cfg_wdata : route_reg;
  // Reinit flag: a wiping stop sets it, a fresh configuration clears it
  assign init_next = wipe ? 1'b1 : cfg_take ? 1'b0 : init_reg;

  // Ninth bit register, cleared by reset or a wiping stop
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      ninth_reg <= SLW_NINTH_RST;
    end else begin
      ninth_reg <= ninth_next;
    end
  end

  // Routing register, cleared the same way
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      route_reg <= '0;
    end else begin
      route_reg <= route_next;
    end
  end

  // Transmit pin synchroniser; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txp_sync_reg <= {2{SLW_LINE_IDLE}};
    end else begin
      txp_sync_reg <= {txp_sync_reg[0], transmit_pin_in};
    end
  end

  // Receive pin synchroniser; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxp_sync_reg <= {2{SLW_LINE_IDLE}};
    end else begin
      rxp_sync_reg <= {rxp_sync_reg[0], receive_pin_in};
    end
  end

  // Transmit pin data follows the transmitter one cycle late
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_out_reg <= SLW_LINE_IDLE;
    end else begin
      tx_out_reg <= tx_out;
    end
  end

  // Transmit pin enable; low hands the line to the remote party
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_oe_reg <= 1'b1;
    end else begin
      tx_oe_reg <= drive_pin;
    end
  end

  // Receive pin release flag for the port logic
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxr_reg <= 1'b0;
    end else begin
      rxr_reg <= release_rx;
    end
  end

  // Receiver serial input after source selection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_in_reg <= SLW_LINE_IDLE;
    end else begin
      rx_in_reg <= rx_sel;
    end
  end

  // Halt status, one cycle behind the power state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= !clk_run;
    end
  end

  // Reinitialisation needed after a wiping stop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      init_reg <= 1'b0;
    end else begin
      init_reg <= init_next;
    end
  end

  // Transmit shifter load; ninth bit travels with data
  slw_shift_reg u_shift (
    .sys_clk(sys_clk),
    .srst(clr),
    .clk_run(clk_run),
    .load(buf_load),
    .load_char({ninth_reg, serial_data_buffer}),
    .held_char(held)
  );
  assign transmit_pin_out = tx_out_reg;
  assign transmit_pin_oe = tx_oe_reg;
  assign receive_pin_released = rxr_reg;
  assign rx_in = rx_in_reg;
  assign shifter_char = held;
  assign route_cfg = route_reg;
  assign clk_halted = halt_reg;
  assign needs_init = init_reg;
endmodule

// ==== verilog/slw_pkg.sv ====
// Package with constants and carrier types for the loop/single-wire control
package slw_pkg;
  // Character width without the ninth bit
  localparam int SLW_DATA_W = 8;
  // Reset values
  localparam logic [7:0] SLW_DATA_RST = 8'h00;
  localparam logic SLW_NINTH_RST = 1'b0;
  localparam logic SLW_LINE_IDLE = 1'b1;
  // Stop mode encoding
  typedef enum logic [1:0] {
    SLW_RUN, SLW_LIGHT_STOP, SLW_PARTIAL_STOP, SLW_DEEPEST_STOP
  } slw_stop_t;
  // Routing configuration
  typedef struct packed {
    logic loopback_enable;
    logic receiver_source_select;
    logic shared_pin_direction;
  } slw_route_t;
  // Character moving into the transmit shifter
  typedef struct packed {
    logic ninth_tx_bit;
    logic [7:0] data;
  } slw_char_t;
endpackage

// ==== verilog/slw_shift_reg.sv ====
// Transmit shifter holding data plus ninth bit, loaded on transfer
`timescale 1ns/1ns
module slw_shift_reg (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic clk_run,
  input wire logic load,
  input wire slw_pkg::slw_char_t load_char,
  // Held character
  output slw_pkg::slw_char_t held_char
);
  import slw_pkg::*;
  slw_char_t held_reg;
  // Captures data and ninth bit together while clocks run
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      held_reg <= '{SLW_NINTH_RST, SLW_DATA_RST};
    end else if (clk_run && load) begin
      held_reg <= load_char;
    end
  end
  assign held_char = held_reg;
endmodule
